// file: override_seq_regs.vh
// constants for the speed override and servo-on sequencer
`ifndef OVERRIDE_SEQ_REGS_VH
`define OVERRIDE_SEQ_REGS_VH
// clock rate and times in their own units
`define CLK_HZ 25000000
`define SON_WAIT_MIN_MS 4000
`define SON_WAIT_MAX_MS 5000
`define READY_DELAY_US 5000
`define CYCLES_PER_MS (`CLK_HZ / 1000)
`define CYCLES_PER_US (`CLK_HZ / 1000000)
// override voltage span and offset limits, millivolts, 18-bit signed
`define SPAN_MIN_MV 18'sh3d8f0
`define SPAN_MAX_MV 18'sh02710
`define OFFSET_MIN_MV 18'sh3d8f1
`define OFFSET_MAX_MV 18'sh0270f
// millivolts at a full-scale adc code
`define MV_FULL_SCALE 32'sh0000_2710
// top of the commanded speed range
`define SPEED_MAX 16'hffff
// percentage scale in hundredths of a percent
`define PCT_AT_ZERO 16'h2710
`define PCT_FULL 16'h4e20
// operating modes
`define MODE_AUTO_POINT 3'h0
`define MODE_AUTO_PROG 3'h1
`define MODE_JOG 3'h2
`define MODE_AUTO_HOME 3'h3
`define MODE_HANDWHEEL 3'h4
`define MODE_HOME_RETURN 3'h5
`define MODE_TEST 3'h6
`endif

// file: speed_override_and_servo_on_sequencer.v
// speed override scaling and servo-on power-up sequencing
//
// Overview of operation
// - override allowed in auto, jog, auto home
// - override ignored in handwheel, home return, test
// - select on: override applies; off: unchanged
// - override tracks input across minus/plus ten volts
// - signed millivolt offset added, clamped to 9999
// - servo-on ignored until 4 to 5 s
// - ready about 5 ms after power stage on
// - alarm clear input drops power stage
// - linear 0/100/200 percent at -10/0/+10 volts
// - override input resolved to fourteen bits
`include "override_seq_regs.vh"
`default_nettype none

module speed_override_and_servo_on_sequencer #(
  parameter ADC_BITS = 14,
  parameter WAIT_MS = (`SON_WAIT_MIN_MS + `SON_WAIT_MAX_MS) / 2,
  parameter integer WAIT_CYCLES = WAIT_MS * `CYCLES_PER_MS,
  parameter integer READY_CYCLES = `READY_DELAY_US * `CYCLES_PER_US
) (
  // clock and reset
  input wire clock_in,
  input wire rst_in,
  // override path
  input wire signed [ADC_BITS-1:0] speed_override_voltage_input_in,
  input wire override_select_input_in,
  input wire signed [14:0] override_offset_setting_in,
  input wire [2:0] operating_mode_in,
  input wire [15:0] set_speed_in,
  output reg [15:0] commanded_speed_out,
  output reg [15:0] override_percent_out,
  // sequencer
  input wire servo_on_input_in,
  input wire alarm_clear_input_in,
  output reg power_stage_on_out,
  output reg ready_out
);

  //////////////////////////////////////////////////////////////////////////
  // sequencer states and override limits

  localparam [1:0] st_wait = 2'h0;
  localparam [1:0] st_idle = 2'h1;
  localparam [1:0] st_settle = 2'h2;
  localparam [1:0] st_ready = 2'h3;

  // 18 bits hold a full-scale reading plus the largest offset
  localparam signed [17:0] offset_lo = `OFFSET_MIN_MV;
  localparam signed [17:0] offset_hi = `OFFSET_MAX_MV;
  localparam signed [17:0] span_lo = `SPAN_MIN_MV;
  localparam signed [17:0] span_hi = `SPAN_MAX_MV;

  //////////////////////////////////////////////////////////////////////////
  // decoders

  function mode_allows;
    input [2:0] mode;
    begin
      case (mode)
        `MODE_AUTO_POINT, `MODE_AUTO_PROG, `MODE_JOG, `MODE_AUTO_HOME:
          mode_allows = 1'b1;
        default: mode_allows = 1'b0;
      endcase
    end
  endfunction

  function signed [15:0] clamp_mv;
    input signed [17:0] v;
    input signed [17:0] lo;
    input signed [17:0] hi;
    begin
      if (v < lo)
        clamp_mv = lo[15:0];
      else if (v > hi)
        clamp_mv = hi[15:0];
      else
        clamp_mv = v[15:0];
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // override path: adc code to millivolts, offset, clamp, percent

  wire signed [31:0] adc_mv_wide;
  wire signed [17:0] adc_mv;
  wire signed [15:0] offset_mv;
  wire signed [15:0] corrected_mv;
  wire [31:0] pct_wide;
  wire [15:0] pct;
  wire [31:0] scaled_wide;
  wire signed [17:0] offset_ext;
  wire scaled_over;
  wire override_active;

  // full scale code maps to ten volts; 14 bits gives ~1.2 mV steps
  assign adc_mv_wide = (speed_override_voltage_input_in * `MV_FULL_SCALE)
    >>> (ADC_BITS - 1);
  assign adc_mv = adc_mv_wide[17:0];
  assign offset_mv = clamp_mv({{3{override_offset_setting_in[14]}},
    override_offset_setting_in}, offset_lo, offset_hi);
  assign offset_ext = {{2{offset_mv[15]}}, offset_mv};

  // clamp before scaling so the percentage never leaves 0..200
  assign corrected_mv = clamp_mv(adc_mv + offset_ext,
    span_lo, span_hi);

  // hundredths of a percent: 10000 at 0 V, one step per mV
  assign pct_wide = $signed({{16{corrected_mv[15]}}, corrected_mv})
    + $signed({16'h0000, `PCT_AT_ZERO});
  assign pct = pct_wide[15:0];
  assign scaled_wide = set_speed_in * pct / `PCT_AT_ZERO;

  // a fast set speed at up to 200 % overflows 16 bits: hold at the top
  assign scaled_over = |scaled_wide[31:16];
  assign override_active = override_select_input_in &&
    mode_allows(operating_mode_in);

  always @(posedge clock_in) begin
    if (rst_in) begin
      commanded_speed_out <= 16'h0000;
      override_percent_out <= `PCT_AT_ZERO;
    end else if (override_active) begin
      if (scaled_over) begin
        commanded_speed_out <= `SPEED_MAX;
      end else begin
        commanded_speed_out <= scaled_wide[15:0];
      end
      override_percent_out <= pct;
    end else begin
      // no change: set speed passes through unscaled
      commanded_speed_out <= set_speed_in;
      override_percent_out <= `PCT_AT_ZERO;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // power-up sequencer

  reg [1:0] state;
  reg [1:0] next_state;
  reg [31:0] count;
  reg [31:0] next_count;
  wire drive_request;
  wire wait_done;
  wire settle_done;

  // clear wins over servo-on, so a held clear keeps the stage off
  assign drive_request = servo_on_input_in && !alarm_clear_input_in;
  assign wait_done = (count >= WAIT_CYCLES - 1);
  assign settle_done = (count >= READY_CYCLES - 1);

  always @* begin
    next_state = state;
    next_count = count;
    case (state)
      st_wait: begin
        // servo-on is not looked at during the power-up wait
        if (wait_done) begin
          next_state = st_idle;
          next_count = 32'h0000_0000;
        end else begin
          next_count = count + 32'h0000_0001;
        end
      end
      st_idle: begin
        // a level held through the wait is acted on here
        if (drive_request) begin
          next_state = st_settle;
          next_count = 32'h0000_0000;
        end
      end
      st_settle: begin
        if (!drive_request) begin
          next_state = st_idle;
        end else if (settle_done) begin
          next_state = st_ready;
        end else begin
          next_count = count + 32'h0000_0001;
        end
      end
      st_ready: begin
        if (!drive_request) begin
          next_state = st_idle;
        end
      end
      default: begin
        next_state = st_wait;
        next_count = 32'h0000_0000;
      end
    endcase
  end

  always @(posedge clock_in) begin
    if (rst_in) begin
      state <= st_wait;
      count <= 32'h0000_0000;
    end else begin
      state <= next_state;
      count <= next_count;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs

  // a drop returns to idle, not to the wait: the wait is power-up only
  always @* begin
    power_stage_on_out = (state == st_settle) || (state == st_ready);
    ready_out = (state == st_ready);
  end

endmodule // speed_override_and_servo_on_sequencer
`default_nettype wire

// file: seq_monitor.sv
// assertion checker for the override and servo-on sequencer
`default_nettype none
module seq_monitor #(parameter int WAIT_CYCLES = 20, READY_CYCLES = 5) (
  input wire logic clock_in, rst_in, override_select_input_in,
  input wire logic signed [13:0] speed_override_voltage_input_in,
  input wire logic signed [14:0] override_offset_setting_in,
  input wire logic [2:0] operating_mode_in,
  input wire logic [15:0] set_speed_in, commanded_speed_out,
  input wire logic [15:0] override_percent_out,
  input wire logic servo_on_input_in, alarm_clear_input_in,
  input wire logic power_stage_on_out, ready_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int up, on;
  wire act = override_select_input_in && operating_mode_in < 3'h4;
  wire zero_offs = override_offset_setting_in == 15'sh0000;
  wire max_offs = override_offset_setting_in == 15'sh270f;
  wire mid_volt = speed_override_voltage_input_in == 14'sh0000;
  wire servo_on_input = servo_on_input_in;
  wire clr = alarm_clear_input_in;
  wire pwr = power_stage_on_out;
  // saturate so a long run cannot wrap the power-up count
  always @(posedge clock_in) begin
    up <= rst_in ? 0 : up + (up < 9999);
    on <= pwr ? on + 1 : 0;
  end
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  sequence son_held_s;
    (servo_on_input && !clr && up > WAIT_CYCLES + 1) ##1 servo_on_input;
  endsequence
  sequence ready_rise_s;
    $rose(ready_out);
  endsequence
  pass_thru_a: assert property (!act |=>
    override_percent_out == 16'h2710 &&
    commanded_speed_out == $past(set_speed_in))
    else $error("override applied while inactive");
  low_end_a: assert property (act && zero_offs &&
    speed_override_voltage_input_in == 14'sh2000 |=>
    override_percent_out == 16'h0000)
    else $error("minus full scale not zero percent");
  offset_add_a: assert property (act && max_offs && mid_volt
    |=> override_percent_out == 16'h4e1f)
    else $error("offset not added");
  pct_range_a: assert property (override_percent_out <= 16'h4e20)
    else $error("percent above span");
  early_power_a: assert property (pwr |-> up >= WAIT_CYCLES)
    else $error("power stage on during wait");
  held_son_a: assert property (son_held_s |-> pwr)
    else $error("held servo-on not acted on");
  ready_delay_a: assert property (ready_rise_s |->
    on inside {[READY_CYCLES - 1:READY_CYCLES + 1]}) else $error("ready delay");
  ready_power_a: assert property (ready_out |-> pwr)
    else $error("ready without power stage");
  clear_drop_a: assert property (clr |=> !pwr && !ready_out)
    else $error("alarm clear left drive on");
endmodule // seq_monitor
bind speed_override_and_servo_on_sequencer seq_monitor #(
  .WAIT_CYCLES(WAIT_CYCLES), .READY_CYCLES(READY_CYCLES)) seq_monitor_i (.*);
`default_nettype wire

// file: controller_model.sv
// controller model driving the select, servo-on and clear contacts
`default_nettype none
module controller_model (
  input wire logic clock_in,
  input wire logic [2:0] cmd_in,
  output logic select_out, servo_out, clear_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {select_out, servo_out, clear_out} = 3'h0;
  // contacts move just after the edge, never on it
  always @(posedge clock_in) begin
    {select_out, servo_out, clear_out} <= #1 cmd_in;
  end
endmodule // controller_model
`default_nettype wire

// file: tb.sv
// self-checking bench for the override and servo-on sequencer
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_in = 0, rst_in = 1;
  logic signed [13:0] volt = 0;
  logic signed [14:0] offs = 0;
  logic [2:0] mode = 0, cmd = 3'h6;
  logic [15:0] set = 16'h03e8;
  wire [15:0] spd, pct;
  wire sel, servo_on_input, clr, pwr, rdy;
  int fail_count, total_checks, cyc, n;
  initial forever #20 clock_in = ~clock_in;
  controller_model controller_model_i (.clock_in(clock_in), .cmd_in(cmd),
    .select_out(sel), .servo_out(servo_on_input), .clear_out(clr));
  speed_override_and_servo_on_sequencer #(.WAIT_CYCLES(60), .READY_CYCLES(5))
    speed_override_and_servo_on_sequencer_i (.clock_in(clock_in),
    .rst_in(rst_in), .speed_override_voltage_input_in(volt),
    .override_select_input_in(sel), .override_offset_setting_in(offs),
    .operating_mode_in(mode), .set_speed_in(set), .commanded_speed_out(spd),
    .override_percent_out(pct), .servo_on_input_in(servo_on_input),
    .alarm_clear_input_in(clr), .power_stage_on_out(pwr), .ready_out(rdy));
  task chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task override_select_input(input logic [2:0] m, input logic signed [13:0] v,
      input logic signed [14:0] o, input logic [15:0] p, c);
    @(posedge clock_in) #1;
    {mode, volt, offs} = {m, v, o};
    @(posedge clock_in) #2;
    chk(pct, p);
    chk(spd, c);
  endtask
  task final_report;
    $display("checks %0d errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 2000) begin
      fail_count++;
      final_report;
    end
  end
  initial begin
    repeat (20) @(posedge clock_in);
    #1 rst_in = 0;
    for (n = 0; n < 4; n++) override_select_input(n, 14'sh1000, 0, 16'h3a98, 16'h05dc);
    for (n = 4; n < 8; n++) override_select_input(n, 14'sh1000, 0, 16'h2710, 16'h03e8);
    override_select_input(0, 14'sh2000, 0, 16'h0000, 16'h0000);
    override_select_input(0, 14'sh1fff, 0, 16'h4e1e, 16'h07cf);
    override_select_input(0, 14'sh0001, 0, 16'h2711, 16'h03e8);
    override_select_input(0, 14'sh0000, 15'sh270f, 16'h4e1f, 16'h07cf);
    override_select_input(0, 14'sh0000, 15'sh4180, 16'h0001, 16'h0000);
    override_select_input(0, 14'sh1fff, 15'sh270f, 16'h4e20, 16'h07d0);
    set = 16'hffff;
    override_select_input(0, 14'sh1000, 0, 16'h3a98, 16'hffff);
    set = 16'h03e8;
    cmd = 3'h2;
    override_select_input(0, 14'sh1000, 0, 16'h2710, 16'h03e8);
    chk(pwr, 0);
    for (n = 0; n < 100 && pwr !== 1'b1; n++) @(posedge clock_in) #2;
    chk(cyc inside {[81:84]}, 1);
    for (n = 0; n < 20 && rdy !== 1'b1; n++) @(posedge clock_in) #2;
    chk(n inside {[4:6]}, 1);
    cmd = 3'h3;
    repeat (3) @(posedge clock_in);
    #2 chk({pwr, rdy}, 0);
    cmd = 3'h2;
    repeat (3) @(posedge clock_in);
    #2 chk(pwr, 1);
    final_report;
  end
endmodule // tb
`default_nettype wire
